// file: core/tbhrh_host_port.sv
// capture buffer fifo and asynchronous host read port of the scan-bus core
`timescale 1ns/100ps

// ============================================================================
// small synchronous fifo, registered occupancy
module tbhrh_fifo
  import tbhrh_pkg::*;
#(
  parameter int unsigned WIDTH = TBHRH_DATA_W,
  parameter int unsigned DEPTH = TBHRH_FIFO_DEPTH
)(
  input  wire logic                     clk,        // core clock
  input  wire logic                     srst,       // sync reset, high
  input  wire logic                     ce,         // clock enable
  input  wire logic                     in_valid,   // producer has a word
  output      logic                     in_ready,   // room for a word
  input  wire logic [WIDTH-1:0]         in_data,    // word written
  output      logic                     out_valid,  // a word is waiting
  input  wire logic                     out_ready,  // consumer takes it
  output      logic [WIDTH-1:0]         out_data,   // oldest word
  output      logic [$clog2(DEPTH):0]   count       // words held
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH) + 1;  // count width

  logic [WIDTH-1:0]       mem_q [DEPTH];
  logic [WIDTH-1:0]       mem_d [DEPTH];
  logic [PW-1:0]          wr_q, wr_d, rd_q, rd_d;
  logic [$clog2(DEPTH):0] cnt_q, cnt_d;
  logic                   push, pop;

  // full and empty come straight from the count, so both are honest
  assign in_ready  = (cnt_q != CW'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign count     = cnt_q;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // next pointers, count and storage
  always_comb
  begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push)
    begin
      mem_d[wr_q] = in_data;
      wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    end
    if (pop)
      rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
    if (push && !pop)
      cnt_d = cnt_q + 1'b1;
    else if (pop && !push)
      cnt_d = cnt_q - 1'b1;
  end

  // registers; storage needs no reset, pointers do
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else if (ce)
    begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end

endmodule // tbhrh_fifo

// ============================================================================
module tbhrh_host_port
  import tbhrh_pkg::*;
#(
  parameter int unsigned DATA_W = TBHRH_DATA_W,
  parameter int unsigned DEPTH  = TBHRH_FIFO_DEPTH
)(
  input  wire logic              clk,                  // core clock
  input  wire logic              srst,                 // sync reset, high
  input  wire logic              ce,                   // clock enable
  // host pins, asynchronous to clk
  input  wire logic              host_strobe_n,        // access strobe
  input  wire logic              host_read,            // 1 read, 0 write
  input  wire logic              host_addr,            // 0 status, 1 buffer
  output      logic [DATA_W-1:0] host_data_out,        // read data
  output      logic              host_data_oe_n,       // low: bus driven
  output      logic              host_ready,           // low inserts waits
  // capture stream from the scan engine, same clock
  input  wire logic              cap_valid,            // captured byte
  output      logic              cap_ready,            // buffer has room
  input  wire logic [DATA_W-1:0] cap_data,             // captured data
  output      logic              capture_buffer_ready_flag, // byte waiting
  // scan bus from the engine and to the pins
  input  wire logic              scan_output_enable_n, // pin, low enables
  input  wire logic              eng_tck,              // engine test clock
  input  wire logic              eng_tms,              // engine mode select
  input  wire logic              eng_tdo,              // engine serial out
  input  wire logic              eng_trst_n,           // engine test reset
  output      logic [3:0]        scan_out,             // tck,tms,tdo,trst_n
  output      logic              scan_oe_n             // low: scan driven
);

  // ==========================================================================
  // pin synchronisers
  localparam int unsigned SW = 4;  // strobe, read, addr, output enable

  logic [SW-1:0] sync1_q, sync1_d, sync2_q, sync2_d;
  logic          stb_prev_q, stb_prev_d;
  logic          stb_n, rd_pin, addr_pin, oe_pin_n;
  logic          stb_fall, stb_rise;

  // only the second stage is ever read by logic, so any strobe phase
  // against clk settles before the sequencer sees it
  always_comb
  begin
    sync1_d     = {host_strobe_n, host_read, host_addr, scan_output_enable_n};
    sync2_d     = sync1_q;
    stb_prev_d  = sync2_q[3];
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sync1_q     <= {TBHRH_PIN_RST_N, 2'b00, TBHRH_PIN_RST_N};
      sync2_q     <= {TBHRH_PIN_RST_N, 2'b00, TBHRH_PIN_RST_N};
      stb_prev_q  <= TBHRH_PIN_RST_N;
    end
    else if (ce)
    begin
      sync1_q     <= sync1_d;
      sync2_q     <= sync2_d;
      stb_prev_q  <= stb_prev_d;
    end
  end

  assign stb_n     = sync2_q[3];
  assign rd_pin    = sync2_q[2];
  assign addr_pin  = sync2_q[1];
  assign oe_pin_n  = sync2_q[0];
  assign stb_fall  = stb_prev_q && !stb_n;
  assign stb_rise  = !stb_prev_q && stb_n;

  // ==========================================================================
  // capture buffer
  logic                   buf_valid, buf_pop;
  logic [DATA_W-1:0]      buf_data;
  logic [$clog2(DEPTH):0] buf_count;

  // engine stalls on cap_ready low when the host falls behind
  tbhrh_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH)
  ) u_buf (
    .clk       (clk),
    .srst      (srst),
    .ce        (ce),
    .in_valid  (cap_valid),
    .in_ready  (cap_ready),
    .in_data   (cap_data),
    .out_valid (buf_valid),
    .out_ready (buf_pop),
    .out_data  (buf_data),
    .count     (buf_count)
  );

  // flag follows the buffer, so a pop that empties it clears the flag
  assign capture_buffer_ready_flag = buf_valid;

  // ==========================================================================
  // status byte
  logic [DATA_W-1:0] status_byte;

  always_comb
  begin
    status_byte = '0;
    status_byte[TBHRH_STAT_READY_BIT] = buf_valid;
    status_byte[TBHRH_STAT_FULL_BIT]  = !cap_ready;
    status_byte[TBHRH_STAT_CNT_LSB +: TBHRH_STAT_CNT_W] =
      TBHRH_STAT_CNT_W'(buf_count);
  end

  // ==========================================================================
  // host access sequencer
  tbhrh_state_t      st_q, st_d;
  logic [DATA_W-1:0] dat_q, dat_d;
  logic              rdy_q, rdy_d;
  logic              oe_n_q, oe_n_d;
  logic              is_buf_q, is_buf_d;

  // a stalled read that the host abandons returns to idle without a pop;
  // the host is expected to wait for ready instead this only keeps
  // a misbehaving host from locking the port
  always_comb
  begin
    st_d     = st_q;
    dat_d    = dat_q;
    rdy_d    = rdy_q;
    oe_n_d   = oe_n_q;
    is_buf_d = is_buf_q;
    buf_pop  = 1'b0;
    case (st_q)
      TBHRH_IDLE:
      begin
        if (stb_fall)
        begin
          if (!rd_pin)
            st_d = TBHRH_DONE;            // writes are not this port's job
          else if (addr_pin == TBHRH_ADDR_STATUS)
          begin
            dat_d    = status_byte;
            oe_n_d   = 1'b0;
            is_buf_d = 1'b0;
            st_d     = TBHRH_SHOW;
          end
          else if (buf_valid)
          begin
            dat_d    = buf_data;
            oe_n_d   = 1'b0;
            is_buf_d = 1'b1;
            st_d     = TBHRH_SHOW;
          end
          else
          begin
            rdy_d    = 1'b0;
            oe_n_d   = 1'b0;
            is_buf_d = 1'b1;
            st_d     = TBHRH_STALL;
          end
        end
      end
      TBHRH_STALL:
      begin
        if (stb_rise)
        begin
          rdy_d  = TBHRH_RDY_RST;
          oe_n_d = 1'b1;
          st_d   = TBHRH_IDLE;
        end
        else if (buf_valid)
        begin
          rdy_d = 1'b1;
          dat_d = buf_data;
          st_d  = TBHRH_SHOW;
        end
      end
      TBHRH_SHOW:
      begin
        // byte is consumed only when the host ends the access
        if (stb_rise)
        begin
          buf_pop = is_buf_q;
          oe_n_d  = 1'b1;
          st_d    = TBHRH_IDLE;
        end
      end
      TBHRH_DONE:
      begin
        if (stb_rise)
          st_d = TBHRH_IDLE;
      end
      default:
      begin
        st_d   = TBHRH_IDLE;
        rdy_d  = TBHRH_RDY_RST;
        oe_n_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_q     <= TBHRH_IDLE;
      dat_q    <= TBHRH_DATA_RST;
      rdy_q    <= TBHRH_RDY_RST;
      oe_n_q   <= 1'b1;
      is_buf_q <= 1'b0;
    end
    else if (ce)
    begin
      st_q     <= st_d;
      dat_q    <= dat_d;
      rdy_q    <= rdy_d;
      oe_n_q   <= oe_n_d;
      is_buf_q <= is_buf_d;
    end
  end

  // ready and data change on the same edge, never ready before the byte
  assign host_data_out  = dat_q;
  assign host_ready     = rdy_q;
  assign host_data_oe_n = oe_n_q;

  // ==========================================================================
  // scan output gating
  logic [3:0] scan_q, scan_d;
  logic       soe_n_q, soe_n_d;

  // engine levels are registered so pins change on clk; enable is low active
  always_comb
  begin
    scan_d  = {eng_tck, eng_tms, eng_tdo, eng_trst_n};
    soe_n_d = oe_pin_n;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      scan_q  <= TBHRH_SCAN_RST;
      soe_n_q <= 1'b1;
    end
    else if (ce)
    begin
      scan_q  <= scan_d;
      soe_n_q <= soe_n_d;
    end
  end

  assign scan_out  = scan_q;
  assign scan_oe_n = soe_n_q;

endmodule // tbhrh_host_port

// file: core/tbhrh_pkg.sv
// shared constants and types for the scan-bus host read port
package tbhrh_pkg;

  // ==========================================================================
  // host port layout
  localparam int unsigned TBHRH_DATA_W      = 8;   // host data bus width
  localparam int unsigned TBHRH_FIFO_DEPTH  = 4;   // capture buffer depth
  localparam int unsigned TBHRH_SYNC_STAGES = 2;   // pin synchroniser depth

  // one address line selects status or capture buffer
  localparam logic        TBHRH_ADDR_STATUS = 1'b0;
  localparam logic        TBHRH_ADDR_BUFFER = 1'b1;

  // ==========================================================================
  // status byte fields
  localparam int unsigned TBHRH_STAT_READY_BIT = 7;  // buffer holds a byte
  localparam int unsigned TBHRH_STAT_FULL_BIT  = 6;  // buffer is full
  localparam int unsigned TBHRH_STAT_CNT_LSB   = 0;  // fill count, low bits
  localparam int unsigned TBHRH_STAT_CNT_W     = 3;

  // ==========================================================================
  // values after reset
  localparam logic [7:0]  TBHRH_DATA_RST  = 8'h00;
  localparam logic        TBHRH_RDY_RST   = 1'b1;
  localparam logic        TBHRH_PIN_RST_N = 1'b1;  // idle level of low pins
  localparam logic [3:0]  TBHRH_SCAN_RST  = 4'h1;  // tck,tms,tdo low, trst_n high

  // ==========================================================================
  // host access sequencer
  typedef enum logic [1:0] {
    TBHRH_IDLE  = 2'b00,  // strobe high, nothing in flight
    TBHRH_STALL = 2'b01,  // buffer read waiting for a byte, ready low
    TBHRH_SHOW  = 2'b10,  // byte or status on the bus, ready high
    TBHRH_DONE  = 2'b11   // non-read access, wait for strobe release
  } tbhrh_state_t;

endpackage : tbhrh_pkg

// file: bench/tbhrh_host_port_props.sv
// concurrent checks on the host read port pins
`timescale 1ns/100ps
// ===========================================================
// port checker
module tbhrh_props
  import tbhrh_pkg::*;
#(
  parameter int unsigned DATA_W = TBHRH_DATA_W,
  parameter int unsigned DEPTH  = TBHRH_FIFO_DEPTH
)(
  input wire logic              clk,            // clock
  input wire logic              srst,           // reset
  input wire logic              host_strobe_n,  // strobe
  input wire logic              host_read,      // read
  input wire logic [DATA_W-1:0] host_data_out,  // data
  input wire logic              host_data_oe_n, // bus drive
  input wire logic              host_ready,     // waits
  input wire logic              cap_valid,      // push
  input wire logic              cap_ready,      // room
  input wire logic [DATA_W-1:0] cap_data,       // byte
  input wire logic              capture_buffer_ready_flag, // held
  input wire logic              scan_output_enable_n,      // pin
  input wire logic              scan_oe_n       // scan drive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  logic [DATA_W-1:0] first_q;
  logic [DATA_W-1:0] first_d;

  // byte landing in an empty buffer; a stalled read must show it
  always_comb
  begin
    first_d = first_q;
    if (cap_valid && cap_ready && !capture_buffer_ready_flag)
      first_d = cap_data;
  end

  // no reset: only looked at after a push has loaded it
  always_ff @(posedge clk)
    first_q <= first_d;

  // ===========================================================
  // assertions
  a_read_answers: assert property (
    $fell(host_strobe_n) && host_read |-> ##[2:4] !host_data_oe_n)
    else $error("read strobe got no answer");
  a_empty_waits: assert property (
    $fell(host_ready) |-> !$past(capture_buffer_ready_flag)
      && !host_data_oe_n)
    else $error("wait state without empty buffer");
  a_wait_ends: assert property (
    !host_ready && capture_buffer_ready_flag |=> host_ready)
    else $error("ready stayed low with a byte held");
  a_byte_on_ready: assert property (
    $rose(host_ready) && !host_data_oe_n |-> host_data_out == first_q)
    else $error("wrong byte when ready returned");
  a_push_flags: assert property (
    cap_valid && cap_ready |=> capture_buffer_ready_flag)
    else $error("flag low after a push");
  a_scan_enable: assert property (
    scan_oe_n == $past(scan_output_enable_n, 3))
    else $error("scan drive does not follow enable");
  a_flag_drop_read: assert property (
    $fell(capture_buffer_ready_flag)
      |-> host_data_oe_n && !$past(host_data_oe_n, 2))
    else $error("flag fell outside a buffer read");

  c_stall: cover property ($fell(host_ready));
  c_full: cover property (!cap_ready);
  c_scan_on: cover property (!scan_oe_n);
endmodule // tbhrh_props

bind tbhrh_host_port tbhrh_props #(.DATA_W(DATA_W), .DEPTH(DEPTH)) u_props (
  .clk, .srst, .host_strobe_n, .host_read, .host_data_out, .host_data_oe_n,
  .host_ready, .cap_valid, .cap_ready, .cap_data, .capture_buffer_ready_flag,
  .scan_output_enable_n, .scan_oe_n);

// file: bench/tbhrh_host_model.sv
// host processor model for the asynchronous read strobe
`timescale 1ns/100ps
// ===========================================================
// host side of the read port
module tbhrh_host_model
  import tbhrh_pkg::*;
(
  input  wire logic       clk,            // clock
  input  wire logic [7:0] host_data_out,  // device data
  input  wire logic       host_data_oe_n, // bus drive
  input  wire logic       host_ready,     // waits
  output      logic       host_strobe_n,  // strobe
  output      logic       host_read,      // read
  output      logic       host_addr       // select
);
  // idle host parks on a status read with the strobe high
  initial
  begin
    host_strobe_n = 1'b1;
    host_read = 1'b1;
    host_addr = TBHRH_ADDR_STATUS;
  end

  // values are checked at the falling edge, so the rising edge that
  // follows sees the same ready; hold plays a slow host
  task automatic access(input logic r, input logic a, input int hold,
                        output logic [7:0] d, output logic ok);
    int n;
    begin
      ok = 1'b0;
      @(negedge clk);
      host_read = r;
      host_addr = a;
      repeat (3) @(negedge clk);
      host_strobe_n = 1'b0;
      for (n = 0; n < 200 && !ok; n++)
      begin
        @(negedge clk);
        ok = host_ready === 1'b1 && (r ? host_data_oe_n === 1'b0 : n > 5);
      end
      d = host_data_out;
      repeat (hold + 1) @(negedge clk);
      host_strobe_n = 1'b1;
      repeat (5) @(negedge clk);
    end
  endtask
endmodule // tbhrh_host_model

// file: bench/tb.sv
// self-checking bench for the scan-bus host read port
`timescale 1ns/100ps
// ===========================================================
// bench top
module tb
  import tbhrh_pkg::*;
;
  logic       clk, srst, ce, host_strobe_n, host_read, host_addr;
  logic       host_data_oe_n, host_ready, cap_valid, cap_ready;
  logic       capture_buffer_ready_flag, scan_output_enable_n, scan_oe_n;
  logic [7:0] host_data_out, cap_data;
  logic [3:0] eng, scan_out;
  int         miscompares = 0;
  int         tests_run = 0;

  tbhrh_host_port u_dut (
    .clk, .srst, .ce, .host_strobe_n, .host_read, .host_addr,
    .host_data_out, .host_data_oe_n, .host_ready, .cap_valid, .cap_ready,
    .cap_data, .capture_buffer_ready_flag, .scan_output_enable_n,
    .eng_tck(eng[3]), .eng_tms(eng[2]), .eng_tdo(eng[1]),
    .eng_trst_n(eng[0]), .scan_out, .scan_oe_n);
  tbhrh_host_model u_host (
    .clk, .host_data_out, .host_data_oe_n, .host_ready, .host_strobe_n,
    .host_read, .host_addr);

  // 250 MHz core clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask

  task automatic stop_test(input bit hung);
    if (hung)
      miscompares++;
    if (miscompares == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one byte from the engine; valid drops at the falling edge after it is taken
  task automatic push(input logic [7:0] b);
    int n;
    @(negedge clk);
    cap_valid = 1'b1;
    cap_data = b;
    for (n = 0; n < 50 && cap_ready !== 1'b1; n++)
      @(negedge clk);
    if (n == 50)
      stop_test(1'b1);
    @(negedge clk);
    cap_valid = 1'b0;
  endtask

  task automatic rd(input logic a, input int hold, output logic [7:0] d);
    logic ok;
    u_host.access(1'b1, a, hold, d, ok);
    if (ok !== 1'b1)
      stop_test(1'b1);
  endtask

  // polling the status flag instead of waiting on ready
  task automatic t_poll;
    logic [7:0] d;
    rd(TBHRH_ADDR_STATUS, 0, d);
    chk(d & 8'hC7, 8'h00);
    push(8'hA5);
    rd(TBHRH_ADDR_STATUS, 0, d);
    chk(d & 8'hC7, 8'h81);
    rd(TBHRH_ADDR_BUFFER, 0, d);
    chk(d, 8'hA5);
    rd(TBHRH_ADDR_STATUS, 0, d);
    chk(d & 8'hC7, 8'h00);
  endtask

  // writes are ignored: no bus drive, no wait, the byte stays put
  task automatic t_write;
    logic [7:0] d;
    logic       ok;
    logic       bad;
    bad = 1'b0;
    push(8'h4D);
    fork
      u_host.access(1'b0, TBHRH_ADDR_BUFFER, 0, d, ok);
      repeat (16) @(negedge clk)
        if (host_data_oe_n !== 1'b1 || host_ready !== 1'b1)
          bad = 1'b1;
    join
    chk({7'h00, ok}, 8'h01);
    chk({7'h00, bad}, 8'h00);
    chk({7'h00, capture_buffer_ready_flag}, 8'h01);
    rd(TBHRH_ADDR_BUFFER, 0, d);
    chk(d, 8'h4D);
  endtask

  // empty buffer read stalls, then takes the late byte
  task automatic t_stall;
    logic [7:0] d;
    int n;
    fork
      rd(TBHRH_ADDR_BUFFER, 0, d);
      begin
        for (n = 0; n < 20 && host_ready !== 1'b0; n++)
          @(negedge clk);
        repeat (6) @(negedge clk);
        chk({7'h00, host_ready}, 8'h00);
        push(8'h6B);
      end
    join
    chk(d, 8'h6B);
  endtask

  // fill until refused, then drain slowly, oldest first
  task automatic t_fill;
    logic [7:0] d;
    logic [7:0] pat [4];
    pat = '{8'h3C, 8'h5A, 8'h96, 8'hF0};
    foreach (pat[i])
      push(pat[i]);
    @(negedge clk);
    cap_valid = 1'b1;
    cap_data = 8'hEE;
    repeat (3) @(negedge clk);
    chk({7'h00, cap_ready}, 8'h00);
    cap_valid = 1'b0;
    rd(TBHRH_ADDR_STATUS, 0, d);
    chk(d & 8'hC7, 8'hC4);
    foreach (pat[i])
    begin
      rd(TBHRH_ADDR_BUFFER, 6, d);
      chk(d, pat[i]);
    end
    chk({7'h00, capture_buffer_ready_flag}, 8'h00);
  endtask

  // scan pins are driven with the engine levels only while enable is low
  task automatic t_scan;
    @(negedge clk);
    scan_output_enable_n = 1'b0;
    eng = 4'hA;
    repeat (4) @(negedge clk);
    chk({7'h00, scan_oe_n}, 8'h00);
    chk({4'h0, scan_out}, 8'h0A);
    scan_output_enable_n = 1'b1;
    repeat (4) @(negedge clk);
    chk({7'h00, scan_oe_n}, 8'h01);
  endtask

  // main sequence
  initial
  begin
    srst = 1'b1;
    ce = 1'b1;
    cap_valid = 1'b0;
    cap_data = 8'h00;
    scan_output_enable_n = 1'b1;
    eng = 4'h1;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    t_poll();
    t_write();
    t_stall();
    t_fill();
    t_scan();
    stop_test(1'b0);
  end
endmodule // tb
